// *** core/apw_regs.vh ***
/*
 * register offsets, field positions, reset values and timing counts for the host power and
 * watchdog sequencer. assumes a 250 MHz aclk and a 32-bit axi4-lite register bus.
 */
`ifndef APW_REGS_VH
`define APW_REGS_VH

// register byte offsets
`define APW_OFF_FUNC      8'h00
`define APW_OFF_PULSE     8'h04
`define APW_OFF_WDOG      8'h08
`define APW_OFF_STAT0     8'h0c
`define APW_OFF_STAT1     8'h10
`define APW_OFF_STAT2     8'h14
`define APW_OFF_STAT3     8'h18
`define APW_OFF_IRQ_STAT  8'h1c
`define APW_OFF_IRQ_MASK  8'h20
`define APW_OFF_KEYCFG    8'h24
`define APW_OFF_MISC      8'h28

// function mask bits
`define APW_BIT_RST_INV   1
`define APW_BIT_PWR_INV   2
`define APW_BIT_WD_ACT    3
`define APW_BIT_BLANK     4
`define APW_BIT_KRESET    5
`define APW_BIT_KPWRON    6
`define APW_BIT_KPWROFF   7

// interrupt status bits
`define APW_IRQ_RESET     0
`define APW_IRQ_PWR       1
`define APW_IRQ_WDOG      2
`define APW_IRQ_SENSE     3

// reset values
`define APW_RST_FUNC      8'h00
`define APW_RST_PULSE     8'h20

// timing
`define APW_CLK_MHZ       250
`define APW_TICK_US       31250
`define APW_TICK_CYC      (`APW_TICK_US * `APW_CLK_MHZ)
`define APW_HOLD_LONG     8'd128
`define APW_HOLD_SHORT    8'd8
`define APW_RST_PULSE_T   8'd32
`define APW_EXTRA_MAX     8'd160
`define APW_SEC_TICKS     6'd32
`define APW_REBOOT_T      8'd4

`endif

// *** core/apw_top.v ***
/*
 * host power and reset sequencer with keypad triggers and a host watchdog, all in one module.
 * assumes synchronous, debounced key inputs and sense input, and an axi4-lite master on aclk.
 */
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "apw_regs.vh"

module apw_top #(
  parameter [31:0] TICK_CYC = `APW_TICK_CYC
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // keypad and host sense
  input  wire        key_confirm,
  input  wire        key_cancel,
  input  wire        host_sense,
  // host lines, driven only during pulses
  output reg         host_reset_o,
  output reg         host_reset_oe,
  output reg         host_power_o,
  output reg         host_power_oe,
  // display and self reboot
  output reg         display_blank,
  output reg         self_reboot,
  // interrupt
  output reg         irq
);

  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_RST    = 3'd1;
  localparam [2:0] ST_PWR    = 3'd2;
  localparam [2:0] ST_EXTRA  = 3'd3;
  localparam [2:0] ST_REBOOT = 3'd4;

  // configuration and status registers
  reg [7:0]  func_ff;
  reg [7:0]  pulse_ff;
  reg [7:0]  wd_ff;
  reg [7:0]  wd_cnt_ff;
  reg [5:0]  wd_sub_ff;
  reg [31:0] stat0_ff;
  reg [31:0] stat1_ff;
  reg [31:0] stat2_ff;
  reg [15:0] keycfg_ff;
  reg [23:0] misc_ff;
  reg [3:0]  ist_ff;
  reg [3:0]  imask_ff;
  // timebase and sequencer
  reg [31:0] tick_cnt_ff;
  reg        tick_ff;
  reg [2:0]  state_ff;
  reg [7:0]  tmr_ff;
  reg        after_rst_ff;
  reg [7:0]  hold_ok_ff;
  reg [7:0]  hold_x_ff;
  reg        sense_d_ff;
  // bus holding
  reg        aw_ff;
  reg        w_ff;
  reg [7:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;

  wire busy     = (state_ff != ST_IDLE);
  wire wr_fire  = aw_ff && w_ff && !s_axi_bvalid;
  wire cmd_ok   = !busy;
  wire wd_on    = (wd_ff != 8'h00);
  wire sense_up = host_sense && !sense_d_ff;
  // host coming up reboots first: a watchdog expiry in the same tick is dropped, the reboot disarms it anyway
  wire sense_reb = sense_up && func_ff[`APW_BIT_BLANK];
  wire wd_fire   = tick_ff && wd_on && (wd_sub_ff == `APW_SEC_TICKS - 6'd1) && (wd_cnt_ff == 8'h01);
  wire key_rst   = tick_ff && host_sense && func_ff[`APW_BIT_KRESET] && key_confirm &&
                   (hold_ok_ff == `APW_HOLD_LONG - 8'd1);
  wire [3:0] irq_set;

  assign irq_set[`APW_IRQ_RESET] = (state_ff == ST_IDLE) && !sense_reb && !wd_fire && key_rst;
  assign irq_set[`APW_IRQ_PWR]   = (state_ff == ST_PWR) && tick_ff && (tmr_ff == 8'd1);
  assign irq_set[`APW_IRQ_WDOG]  = (state_ff == ST_IDLE) && !sense_reb && wd_fire;
  assign irq_set[`APW_IRQ_SENSE] = (state_ff == ST_IDLE) && sense_reb;

  function [7:0] merge8;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
      merge8 = en ? nw : old;
    end
  endfunction

  function [7:0] sat_inc;
    input [7:0] v;
    begin
      sat_inc = (v == 8'hff) ? v : v + 8'd1;
    end
  endfunction

  function [31:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `APW_OFF_FUNC:     rd_mux = {24'h000000, func_ff};
        `APW_OFF_PULSE:    rd_mux = {24'h000000, pulse_ff};
        `APW_OFF_WDOG:     rd_mux = {24'h000000, wd_ff};
        // status bytes 0..3: fan and temperature reporting
        `APW_OFF_STAT0:    rd_mux = stat0_ff;
        // bytes 4..7: temperature, key press, key release, function | watchdog active
        `APW_OFF_STAT1:    rd_mux = {func_ff | (wd_on ? 8'h08 : 8'h00), keycfg_ff[15:8],
                                     keycfg_ff[7:0], stat1_ff[7:0]};
        // bytes 8..11: watchdog countdown, glitch delays 0..2
        `APW_OFF_STAT2:    rd_mux = {stat2_ff[23:0], wd_cnt_ff};
        // bytes 12..14: glitch delay 3, contrast, backlight
        `APW_OFF_STAT3:    rd_mux = {8'h00, misc_ff};
        `APW_OFF_IRQ_STAT: rd_mux = {28'h0000000, ist_ff};
        `APW_OFF_IRQ_MASK: rd_mux = {28'h0000000, imask_ff};
        `APW_OFF_KEYCFG:   rd_mux = {16'h0000, keycfg_ff};
        `APW_OFF_MISC:     rd_mux = {8'h00, misc_ff};
        default:           rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  // write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff         <= 1'b0;
      w_ff          <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h00000000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // while a sequence runs, writes are answered but refused
        s_axi_bresp  <= cmd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux(s_axi_araddr);
        s_axi_rresp  <= 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // 1/32 second timebase
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == TICK_CYC - 32'h00000001) begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      tick_ff     <= 1'b0;
    end
  end

  // configuration, watchdog, sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      func_ff       <= `APW_RST_FUNC;
      pulse_ff      <= `APW_RST_PULSE;
      wd_ff         <= 8'h00;
      wd_cnt_ff     <= 8'h00;
      wd_sub_ff     <= 6'h00;
      stat0_ff      <= 32'h00000000;
      stat1_ff      <= 32'h00000000;
      stat2_ff      <= 32'h00000000;
      keycfg_ff     <= 16'h0000;
      misc_ff       <= 24'h000000;
      ist_ff        <= 4'h0;
      imask_ff      <= 4'h0;
      state_ff      <= ST_IDLE;
      tmr_ff        <= 8'h00;
      after_rst_ff  <= 1'b0;
      hold_ok_ff    <= 8'h00;
      hold_x_ff     <= 8'h00;
      sense_d_ff    <= 1'b0;
      host_reset_o  <= 1'b0;
      host_reset_oe <= 1'b0;
      host_power_o  <= 1'b0;
      host_power_oe <= 1'b0;
      display_blank <= 1'b0;
      self_reboot   <= 1'b0;
      irq           <= 1'b0;
    end else begin
      sense_d_ff  <= host_sense;
      self_reboot <= 1'b0;
      // polarity: drive low unless invert bit set
      host_reset_o <= func_ff[`APW_BIT_RST_INV];
      host_power_o <= func_ff[`APW_BIT_PWR_INV];
      display_blank <= func_ff[`APW_BIT_BLANK] && !host_sense;
      irq <= |(ist_ff & imask_ff);

      // register writes, only while idle
      if (wr_fire && cmd_ok) begin
        case (awaddr_ff)
          `APW_OFF_FUNC:     func_ff  <= merge8(func_ff, wdata_ff[7:0] & 8'hf6, wstrb_ff[0]);
          `APW_OFF_PULSE:    if (wstrb_ff[0] && wdata_ff[7:0] != 8'h00)
                               pulse_ff <= wdata_ff[7:0];
          `APW_OFF_WDOG:     if (wstrb_ff[0]) begin
                               wd_ff     <= wdata_ff[7:0];
                               wd_cnt_ff <= wdata_ff[7:0];
                               wd_sub_ff <= 6'h00;
                             end
          `APW_OFF_STAT0:    stat0_ff <= wdata_ff;
          `APW_OFF_STAT1:    stat1_ff <= wdata_ff;
          `APW_OFF_STAT2:    stat2_ff <= wdata_ff;
          `APW_OFF_IRQ_MASK: if (wstrb_ff[0]) imask_ff <= wdata_ff[3:0];
          `APW_OFF_KEYCFG:   keycfg_ff <= wdata_ff[15:0];
          `APW_OFF_MISC:     misc_ff <= wdata_ff[23:0];
          default:           ;
        endcase
      end

      // write-one-to-clear, a new event wins over the clear; a refused write clears nothing
      if (wr_fire && cmd_ok && awaddr_ff == `APW_OFF_IRQ_STAT && wstrb_ff[0])
        ist_ff <= (ist_ff & ~wdata_ff[3:0]) | irq_set;
      else
        ist_ff <= ist_ff | irq_set;

      // key hold timers count in 1/32 s ticks, cleared on release
      if (!key_confirm || busy)
        hold_ok_ff <= 8'h00;
      else if (tick_ff)
        hold_ok_ff <= sat_inc(hold_ok_ff);
      if (!key_cancel || busy)
        hold_x_ff <= 8'h00;
      else if (tick_ff)
        hold_x_ff <= sat_inc(hold_x_ff);

      case (state_ff)
        ST_IDLE: begin
          // watchdog countdown in seconds
          if (wd_on && tick_ff) begin
            if (wd_sub_ff == `APW_SEC_TICKS - 6'd1) begin
              wd_sub_ff <= 6'h00;
              if (wd_cnt_ff == 8'h01) begin
                wd_ff     <= 8'h00;
                wd_cnt_ff <= 8'h00;
              end else begin
                wd_cnt_ff <= wd_cnt_ff - 8'd1;
              end
            end else begin
              wd_sub_ff <= wd_sub_ff + 6'd1;
            end
          end
          if (sense_reb) begin
            state_ff <= ST_REBOOT;
            tmr_ff   <= `APW_REBOOT_T;
          end else if (wd_fire) begin
            state_ff      <= ST_RST;
            tmr_ff        <= `APW_RST_PULSE_T;
            host_reset_oe <= 1'b1;
          end else if (key_rst) begin
            state_ff      <= ST_RST;
            tmr_ff        <= `APW_RST_PULSE_T;
            host_reset_oe <= 1'b1;
          end else if (tick_ff && !host_sense && func_ff[`APW_BIT_KPWRON] && key_confirm &&
                       hold_ok_ff == `APW_HOLD_SHORT - 8'd1) begin
            state_ff      <= ST_PWR;
            after_rst_ff  <= 1'b1;
            tmr_ff        <= pulse_ff;
            host_power_oe <= 1'b1;
          end else if (tick_ff && host_sense && func_ff[`APW_BIT_KPWROFF] && key_cancel &&
                       hold_x_ff == `APW_HOLD_LONG - 8'd1) begin
            state_ff      <= ST_PWR;
            after_rst_ff  <= 1'b0;
            tmr_ff        <= pulse_ff;
            host_power_oe <= 1'b1;
          end
        end
        ST_RST: begin
          if (tick_ff) begin
            if (tmr_ff == 8'd1) begin
              host_reset_oe <= 1'b0;
              state_ff      <= ST_REBOOT;
              tmr_ff        <= `APW_REBOOT_T;
            end else begin
              tmr_ff <= tmr_ff - 8'd1;
            end
          end
        end
        ST_PWR: begin
          if (tick_ff) begin
            if (tmr_ff == 8'd1) begin
              if (!after_rst_ff && key_cancel) begin
                state_ff <= ST_EXTRA;
                tmr_ff   <= `APW_EXTRA_MAX;
              end else begin
                host_power_oe <= 1'b0;
                state_ff      <= after_rst_ff ? ST_REBOOT : ST_IDLE;
                tmr_ff        <= `APW_REBOOT_T;
              end
            end else begin
              tmr_ff <= tmr_ff - 8'd1;
            end
          end
        end
        ST_EXTRA: begin
          if (!key_cancel || (tick_ff && tmr_ff == 8'd1)) begin
            host_power_oe <= 1'b0;
            state_ff      <= ST_IDLE;
            tmr_ff        <= 8'h00;
          end else if (tick_ff) begin
            tmr_ff <= tmr_ff - 8'd1;
          end
        end
        ST_REBOOT: begin
          self_reboot <= 1'b1;
          if (tick_ff) begin
            if (tmr_ff == 8'd1) begin
              state_ff  <= ST_IDLE;
              wd_ff     <= 8'h00;
              wd_cnt_ff <= 8'h00;
            end else begin
              tmr_ff <= tmr_ff - 8'd1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // apw_top

// *** testbench/apw_top_sva.sv ***
/* assertions on apw_top ports: pulse widths, reboot timing and refusals.
   assumes TICK_CYC equals the instance value and aresetn is synchronous. */
`timescale 1ns/100ps
module apw_top_sva #(
  parameter int TICK_CYC = 4
) (
  // clock and reset
  input logic       aclk,
  input logic       aresetn,
  // observed ports
  input logic       s_axi_bvalid,
  input logic [1:0] s_axi_bresp,
  input logic       host_sense,
  input logic       host_reset_o,
  input logic       host_reset_oe,
  input logic       host_power_o,
  input logic       host_power_oe,
  input logic       display_blank,
  input logic       self_reboot
);
  logic [15:0] rst_len_ff;
  logic [15:0] pwr_len_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // width counters, so whole pulses are judged rather than single edges
  always @(posedge aclk) begin
    rst_len_ff <= (aresetn && host_reset_oe) ? rst_len_ff + 16'h0001 : 16'h0000;
    pwr_len_ff <= (aresetn && host_power_oe) ? pwr_len_ff + 16'h0001 : 16'h0000;
  end
  rst_width_a: assert property ($fell(host_reset_oe) |->
    rst_len_ff > 31*TICK_CYC && rst_len_ff <= 32*TICK_CYC)
    else $error("reset pulse width wrong");
  rst_reboot_a: assert property ($fell(host_reset_oe) |-> ##[0:8] self_reboot)
    else $error("no reboot after reset pulse");
  reboot_hold_a: assert property ($rose(self_reboot) |-> self_reboot[*4])
    else $error("reboot phase too short");
  reboot_quiet_a: assert property (self_reboot |-> !host_reset_oe && !host_power_oe)
    else $error("line driven during reboot");
  busy_refuse_a: assert property ($rose(s_axi_bvalid) && self_reboot |-> s_axi_bresp == 2'b10)
    else $error("write accepted during reboot");
  pwr_max_a: assert property (host_power_oe |-> pwr_len_ff < 415*TICK_CYC)
    else $error("power pulse too long");
  rst_level_a: assert property (host_reset_oe && $past(host_reset_oe) |-> $stable(host_reset_o))
    else $error("reset level moved in pulse");
  pwr_level_a: assert property (host_power_oe && $past(host_power_oe) |-> $stable(host_power_o))
    else $error("power level moved in pulse");
  blank_cause_a: assert property (display_blank |-> !$past(host_sense))
    else $error("blank while host on");
  sense_boot_a: assert property ($rose(host_sense) && display_blank && !self_reboot &&
    !host_power_oe && !host_reset_oe |-> ##[1:12] self_reboot)
    else $error("no reboot on sense rise");
endmodule // apw_top_sva

bind apw_top apw_top_sva #(.TICK_CYC(TICK_CYC)) apw_top_sva_inst (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bresp,
  .host_sense, .host_reset_o, .host_reset_oe, .host_power_o, .host_power_oe, .display_blank, .self_reboot);

// *** testbench/apw_host_model.sv ***
/* behavioural host: its power switch input toggles the host state.
   assumes act_hi gives the pressed level; a released line reads as pulled up. */
`timescale 1ns/100ps
module apw_host_model (
  // clock
  input  logic aclk,
  // power switch line from the sequencer
  input  logic pwr_o,
  input  logic pwr_oe,
  input  logic act_hi,
  // host state
  output logic sense
);
  logic       pwr_line;
  logic       press;
  logic       was_ff = 1'b0;
  logic       on_ff  = 1'b0;
  logic [5:0] dly_ff = 6'h00;
  assign pwr_line = pwr_oe ? pwr_o : 1'b1;
  assign press    = pwr_oe && pwr_line == act_hi;
  assign sense    = on_ff;
  // supplies settle well after release, so the sense edge never lands in a reboot
  always @(posedge aclk) begin
    was_ff <= press;
    if (was_ff && !press) dly_ff <= 6'h28;
    else if (dly_ff != 6'h00) dly_ff <= dly_ff - 6'h01;
    if (dly_ff == 6'h01) on_ff <= !on_ff;
  end
endmodule // apw_host_model

// *** testbench/apw_top_tb_top.sv ***
/* self-checking bench for apw_top: random config, key holds, watchdog, irq.
   assumes apw_host_model as the host and a short tick for simulation. */
`timescale 1ns/100ps
`include "apw_regs.vh"
module apw_top_tb_top;
  localparam int T = 4;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, kc = 0, kx = 0;
  logic [7:0]  aw = 0, ar = 0, fv = 0, pv = 0, wdt = 0;
  logic [31:0] wd = 0, rv;
  logic [1:0]  br;
  logic        rlvl, plvl;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         awr, wr_r, bv, arr, rvl, rst_o, rst_oe, pwr_o, pwr_oe, blank, reboot, irq, sense;
  int          err_total = 0, cmp_count = 0, cyc = 0, rlen = 0, plen = 0, rl, pl, rn = 0, pn = 0, rb = 0;

  apw_top #(.TICK_CYC(T)) apw_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rry), .key_confirm(kc),
    .key_cancel(kx), .host_sense(sense), .host_reset_o(rst_o), .host_reset_oe(rst_oe), .host_power_o(pwr_o),
    .host_power_oe(pwr_oe), .display_blank(blank), .self_reboot(reboot), .irq(irq));
  apw_host_model apw_host_model_inst (.aclk(aclk), .pwr_o(pwr_o), .pwr_oe(pwr_oe), .act_hi(fv[2]), .sense(sense));

  initial forever #2 aclk = ~aclk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] fits(input int len, input int lo, input int hi);
    return 32'(len > lo && len <= hi);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw  <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    br = bresp;
    bry <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    ar  <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rvl);
    rv = rdata;
    chk(32'(rresp), 32'h0);
    rry <= 1'b0;
    @(posedge aclk);
  endtask

  // pulse monitors: width in cycles and the level held while driven
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rst_oe) begin
      rlen++;
      rlvl = rst_o;
    end else if (rlen != 0) begin
      rl = rlen;
      rlen = 0;
      rn++;
    end
    if (pwr_oe) begin
      plen++;
      plvl = pwr_o;
    end else if (plen != 0) begin
      pl = plen;
      plen = 0;
      pn++;
    end
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  always @(posedge reboot) rb++;

  initial begin
    void'($urandom(32'h41cb8314));
    fv  = 8'hf0 | (8'($urandom) & 8'h06);
    pv  = 8'd2 + 8'($urandom % 8);
    wdt = 8'd2 + 8'($urandom % 2);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`APW_OFF_FUNC);
    chk(rv, 32'(`APW_RST_FUNC));
    rd(`APW_OFF_PULSE);
    chk(rv, 32'(`APW_RST_PULSE));
    rd(8'h3c);
    chk(rv, 32'h0);
    wr(`APW_OFF_PULSE, 32'h0);
    rd(`APW_OFF_PULSE);
    chk(rv, 32'(`APW_RST_PULSE));
    wr(`APW_OFF_PULSE, 32'(pv));
    wr(`APW_OFF_FUNC, 32'(fv | 8'h08));
    rd(`APW_OFF_FUNC);
    chk(rv, 32'(fv));
    wr(`APW_OFF_WDOG, 32'(wdt));
    wr(`APW_OFF_WDOG, 32'h0);
    rd(`APW_OFF_STAT1);
    chk(32'(rv[31:24]), 32'(fv));
    chk(32'(blank), 32'h1);
    // a short confirm tap must not reach the threshold
    kc <= 1'b1;
    repeat (4*T) @(posedge aclk);
    kc <= 1'b0;
    repeat (4*T) @(posedge aclk);
    chk(pn, 0);
    kc <= 1'b1;
    repeat (12*T) @(posedge aclk);
    kc <= 1'b0;
    while (!sense) @(posedge aclk);
    repeat (16) @(posedge aclk);
    while (reboot) @(posedge aclk);
    chk(pn, 1);
    chk(fits(pl, (pv-1)*T, pv*T), 1);
    chk(32'(plvl), 32'(fv[2]));
    chk(rb, 2);
    rd(`APW_OFF_IRQ_STAT);
    chk(rv, 32'h0a);
    wr(`APW_OFF_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    wr(`APW_OFF_IRQ_MASK, 32'h0a);
    chk(32'(irq), 32'h1);
    wr(`APW_OFF_IRQ_STAT, 32'h0a);
    chk(32'(irq), 32'h0);
    wr(`APW_OFF_WDOG, 32'(wdt));
    rd(`APW_OFF_STAT1);
    chk(32'(rv[27]), 32'h1);
    rd(`APW_OFF_STAT2);
    chk(32'(rv[7:0]), 32'(wdt));
    repeat (60) @(posedge aclk);
    wr(`APW_OFF_WDOG, 32'(wdt));
    repeat (100) @(posedge aclk);
    chk(rn, 0);
    while (rn == 0) @(posedge aclk);
    chk(fits(rl, 31*T, 32*T), 1);
    chk(32'(rlvl), 32'(fv[1]));
    while (!reboot) @(posedge aclk);
    wr(`APW_OFF_FUNC, 32'h0);
    chk(32'(br), 32'h2);
    while (reboot) @(posedge aclk);
    rd(`APW_OFF_STAT1);
    chk(32'(rv[31:24]), 32'(fv));
    repeat (400) @(posedge aclk);
    chk(rn, 1);
    kc <= 1'b1;
    repeat (135*T) @(posedge aclk);
    kc <= 1'b0;
    while (rn < 2) @(posedge aclk);
    chk(fits(rl, 31*T, 32*T), 1);
    while (!reboot) @(posedge aclk);
    while (reboot) @(posedge aclk);
    // cancel is held past the base pulse to stretch it
    kx <= 1'b1;
    while (!pwr_oe) @(posedge aclk);
    repeat ((pv+10)*T) @(posedge aclk);
    kx <= 1'b0;
    while (pn < 2) @(posedge aclk);
    chk(fits(pl, (pv+9)*T, (pv+11)*T+2), 1);
    while (sense) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk(32'(blank), 32'h1);
    conclude();
  end
endmodule // apw_top_tb_top
